// file: hdl/nrs_exec.sv
/*
  Execution slice for rotate-right-through-carry, return-from-subroutine and the four
  subtract-with-borrow forms, with the data RAM held locally.
  Assumes the fetch logic presents one decoded-ready word per cycle with valid, that the
  return stack sits outside and offers its top entry, and that all inputs are on mclk.
*/
`timescale 1ns/1ps
module nrs_exec (
  input wire logic mclk,
  input wire logic rst_n,
  input wire nrs_pkg::nrs_instr_t instr,
  input wire logic [nrs_pkg::PC_W-1:0] stack_top,
  input wire nrs_pkg::nrs_ram_wr_t ram_load,
  input wire logic [nrs_pkg::ADDR_W-1:0] peek_addr,
  output logic [nrs_pkg::NIB_W-1:0] peek_data,
  output logic [nrs_pkg::NIB_W-1:0] result_nibble_register,
  output logic carry_flag,
  output logic zero_flag,
  output logic [nrs_pkg::PC_W-1:0] pc,
  output logic stack_pop,
  output nrs_pkg::nrs_ram_wr_t ram_wr
);
  logic [nrs_pkg::NIB_W-1:0] ram_q [nrs_pkg::RAM_DEPTH];
  logic [nrs_pkg::NIB_W-1:0] acc_q, acc_d;
  logic cf_q, cf_d, zf_q, zf_d;
  logic [nrs_pkg::PC_W-1:0] pc_q, pc_d;
  logic [nrs_pkg::NIB_W-1:0] peek_q;
  nrs_pkg::nrs_ram_wr_t wr_q, wr_d;

  // Opcode decode; RAM-operand forms use a 9-bit prefix, immediate forms an 8-bit one
  wire is_rrc = instr.valid && (instr.word[15:7] == nrs_pkg::OP_ROT_RIGHT);
  wire is_sbc_m = instr.valid && (instr.word[15:7] == nrs_pkg::OP_SUB_MEM);
  wire is_subtract_with_borrow_writeback_m = instr.valid && (instr.word[15:7] == nrs_pkg::OP_SUB_MEM_WB);
  wire is_sbc_i = instr.valid && (instr.word[15:8] == nrs_pkg::OP_SUB_IMM);
  wire is_subtract_with_borrow_writeback_i = instr.valid && (instr.word[15:8] == nrs_pkg::OP_SUB_IMM_WB);
  wire is_rtn = instr.valid && (instr.word == nrs_pkg::OP_RETURN);
  wire is_mem_op = is_rrc || is_sbc_m || is_subtract_with_borrow_writeback_m;
  wire is_imm_op = is_sbc_i || is_subtract_with_borrow_writeback_i;
  wire is_sub = is_sbc_m || is_subtract_with_borrow_writeback_m || is_imm_op;
  wire is_wb = is_rrc || is_subtract_with_borrow_writeback_m || is_subtract_with_borrow_writeback_i;

  // Operand selection: working registers are the low 16 RAM nibbles
  wire [nrs_pkg::NIB_W-1:0] imm = instr.word[nrs_pkg::IMM_LSB +: nrs_pkg::NIB_W];
  wire [nrs_pkg::ADDR_W-1:0] wr_addr = {3'h0, instr.word[nrs_pkg::WSEL_LSB +: nrs_pkg::NIB_W]};
  wire [nrs_pkg::ADDR_W-1:0] opnd_addr = is_imm_op ? wr_addr : instr.word[nrs_pkg::ADDR_W-1:0];
  wire [nrs_pkg::NIB_W-1:0] mem_opnd = ram_q[opnd_addr];
  wire [nrs_pkg::NIB_W-1:0] sub_rhs = is_imm_op ? imm : acc_q;

  // Borrow falls out as bit 4 of a 5-bit difference
  wire [nrs_pkg::NIB_W:0] sub_diff = {1'b0, mem_opnd} - {1'b0, sub_rhs} - {4'h0, cf_q};
  wire [nrs_pkg::NIB_W-1:0] rot_res = {cf_q, mem_opnd[3:1]};

  // Next-state: every listed instruction completes in this one cycle
  always_comb begin
    acc_d = acc_q;
    cf_d = cf_q;
    zf_d = zf_q;
    pc_d = pc_q;
    wr_d = '0;
    if (is_rrc) begin
      acc_d = rot_res;
      cf_d = mem_opnd[0];
      zf_d = (rot_res == 4'h0);
    end else if (is_sub) begin
      acc_d = sub_diff[nrs_pkg::NIB_W-1:0];
      cf_d = sub_diff[nrs_pkg::NIB_W];
      zf_d = (sub_diff[nrs_pkg::NIB_W-1:0] == 4'h0);
    end
    if (is_wb) begin
      wr_d.we = 1'b1;
      wr_d.addr = opnd_addr;
      wr_d.data = is_rrc ? rot_res : sub_diff[nrs_pkg::NIB_W-1:0];
    end
    // Fetch sequencing lives elsewhere; here the PC loads stack_top on a return and otherwise steps past each valid word
    if (is_rtn) begin
      pc_d = stack_top;
    end else if (instr.valid) begin
      pc_d = pc_q + 11'h001;
    end
  end

  // Core state, synchronous reset
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      acc_q <= nrs_pkg::RESULT_RST;
      cf_q <= nrs_pkg::FLAG_RST;
      zf_q <= nrs_pkg::FLAG_RST;
      pc_q <= nrs_pkg::PC_RST;
      wr_q <= '0;
    end else begin
      acc_q <= acc_d;
      cf_q <= cf_d;
      zf_q <= zf_d;
      pc_q <= pc_d;
      wr_q <= wr_d;
    end
  end

  // RAM: execution write-back beats an external load in the same cycle; contents are not reset
  // A load issued in the same cycle as a write-back is lost, so the rest of the core must not overlap them
  always_ff @(posedge mclk) begin
    if (wr_d.we) begin
      ram_q[wr_d.addr] <= wr_d.data;
    end else if (ram_load.we) begin
      ram_q[ram_load.addr] <= ram_load.data;
    end
  end

  // Registered observation port, reads the array as it stood before the edge
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      peek_q <= 4'h0;
    end else begin
      peek_q <= ram_q[peek_addr];
    end
  end

  // Data outputs come straight from flip-flops
  assign peek_data = peek_q;
  assign result_nibble_register = acc_q;
  assign carry_flag = cf_q;
  assign zero_flag = zf_q;
  assign pc = pc_q;
  assign ram_wr = wr_q;
  // Pop acknowledge is combinational so the stack can retire its entry on the same edge
  assign stack_pop = is_rtn;

  // Checks
  // Each property but the stack_pop check in a_rtn_pc_reload looks one edge after the executing cycle, where the registered outputs have settled
  a_rrc_decode_done: assert property (@(posedge mclk) disable iff (!rst_n)
    is_rrc |=> ram_wr.we && ram_wr.addr == $past(instr.word[6:0]))
    else $error("rotate-right not completed in one cycle");

  a_rrc_rotate_value: assert property (@(posedge mclk) disable iff (!rst_n)
    is_rrc |=> result_nibble_register == {$past(cf_q), $past(mem_opnd[3:1])} &&
      carry_flag == $past(mem_opnd[0]) && ram_wr.data == result_nibble_register &&
      zero_flag == (result_nibble_register == 4'h0))
    else $error("rotate-right result or flags wrong");

  a_rtn_pc_reload: assert property (@(posedge mclk) disable iff (!rst_n)
    is_rtn |-> stack_pop ##1 (pc == $past(stack_top) && !ram_wr.we))
    else $error("return did not reload the program counter");

  a_sub_mem_only: assert property (@(posedge mclk) disable iff (!rst_n)
    is_sbc_m |=> !ram_wr.we &&
      result_nibble_register == $past(mem_opnd) - $past(acc_q) - {3'h0, $past(cf_q)})
    else $error("memory subtract result wrong or memory written");

  a_sub_imm_only: assert property (@(posedge mclk) disable iff (!rst_n)
    is_sbc_i |=> !ram_wr.we &&
      result_nibble_register == $past(ram_q[wr_addr]) - $past(imm) - {3'h0, $past(cf_q)})
    else $error("immediate subtract result wrong or register written");

  a_sub_mem_wb: assert property (@(posedge mclk) disable iff (!rst_n)
    is_subtract_with_borrow_writeback_m |=> ram_wr.we && ram_wr.addr == $past(instr.word[6:0]) &&
      ram_wr.data == result_nibble_register &&
      result_nibble_register == $past(mem_opnd) - $past(acc_q) - {3'h0, $past(cf_q)})
    else $error("memory subtract write-back wrong");

  a_sub_imm_wb: assert property (@(posedge mclk) disable iff (!rst_n)
    is_subtract_with_borrow_writeback_i |=> ram_wr.we && ram_wr.addr == {3'h0, $past(instr.word[3:0])} &&
      ram_wr.data == result_nibble_register &&
      result_nibble_register == $past(ram_q[wr_addr]) - $past(imm) - {3'h0, $past(cf_q)})
    else $error("immediate subtract write-back wrong");

  a_sub_flags: assert property (@(posedge mclk) disable iff (!rst_n)
    is_sub |=> zero_flag == (result_nibble_register == 4'h0) &&
      carry_flag == ({1'b0, $past(mem_opnd)} < ({1'b0, $past(sub_rhs)} + {4'h0, $past(cf_q)})))
    else $error("subtract flags wrong");

  // Every rotate is one machine cycle: the PC has moved on by exactly one word
  a_rrc_pc_step: assert property (@(posedge mclk) disable iff (!rst_n)
    is_rrc |=> pc == $past(pc) + 11'h001)
    else $error("rotate-right took more than one cycle");

  // Zero flag worked out from the operand bits, not from the result register
  a_rrc_zero_flag: assert property (@(posedge mclk) disable iff (!rst_n)
    is_rrc |=> zero_flag == ($past(mem_opnd[3:1]) == 3'h0 && !$past(cf_q)))
    else $error("rotate-right zero flag wrong");

  // A shown write-back must really sit in the array by then
  a_wb_reaches_ram: assert property (@(posedge mclk) disable iff (!rst_n)
    ram_wr.we |-> ram_q[ram_wr.addr] == ram_wr.data)
    else $error("write-back missing from the data memory");

  // A return touches only the PC; the datapath state carries straight through
  a_rtn_keeps_datapath: assert property (@(posedge mclk) disable iff (!rst_n)
    is_rtn |=> result_nibble_register == $past(result_nibble_register) &&
      carry_flag == $past(carry_flag) && zero_flag == $past(zero_flag))
    else $error("return disturbed the result or flags");

  // The top PC bit must come from the stack too, not be left at zero
  a_rtn_pc_msb: assert property (@(posedge mclk) disable iff (!rst_n)
    is_rtn |=> pc[nrs_pkg::PC_W-1] == $past(stack_top[nrs_pkg::PC_W-1]))
    else $error("return lost the top program counter bit");

  // Memory-only subtract leaves its operand nibble where it was
  a_sub_mem_ram_kept: assert property (@(posedge mclk) disable iff (!rst_n)
    is_sbc_m && !ram_load.we |=> ram_q[$past(opnd_addr)] == $past(mem_opnd))
    else $error("memory subtract changed the memory nibble");

  // Immediate subtract without write-back leaves the working register alone
  a_sub_imm_ram_kept: assert property (@(posedge mclk) disable iff (!rst_n)
    is_sbc_i && !ram_load.we |=> ram_q[$past(wr_addr)] == $past(mem_opnd))
    else $error("immediate subtract changed the working register");

  // Subtracts are single-cycle as well
  a_sub_pc_step: assert property (@(posedge mclk) disable iff (!rst_n)
    is_sub |=> pc == $past(pc) + 11'h001)
    else $error("subtract took more than one cycle");

  // Zero together with a borrow is only reachable as 0 - 15 - 1
  a_sub_zero_borrow: assert property (@(posedge mclk) disable iff (!rst_n)
    is_sub |=> !(zero_flag && carry_flag) ||
      ($past(mem_opnd) == 4'h0 && $past(sub_rhs) == 4'hf && $past(cf_q)))
    else $error("zero and borrow set together without full wrap");
endmodule // nrs_exec

// file: hdl/nrs_pkg.sv
/*
  Shared constants and carrier types for the nibble rotate / subtract / return execution slice.
  Assumes a 16-bit instruction word and a 128 x 4 data RAM whose first 16 nibbles are the working registers.
*/
package nrs_pkg;
  // Widths
  localparam int NIB_W = 4;
  localparam int ADDR_W = 7;
  localparam int PC_W = 11;
  localparam int WORD_W = 16;
  localparam int RAM_DEPTH = 128;

  // Opcode prefixes, compared against the top bits of the word; OP_RETURN is matched against the whole word
  localparam logic [8:0] OP_ROT_RIGHT = 9'h09b; // 010011011 + R6..R0
  localparam logic [8:0] OP_SUB_MEM = 9'h014; // 000010100 + R6..R0
  localparam logic [8:0] OP_SUB_MEM_WB = 9'h016; // 000010110 + R6..R0
  localparam logic [7:0] OP_SUB_IMM = 8'h0e; // 00001110 + I3..I0 + W3..W0
  localparam logic [7:0] OP_SUB_IMM_WB = 8'h0f; // 00001111 + I3..I0 + W3..W0
  localparam logic [15:0] OP_RETURN = 16'h0200; // 00000010000000 then 00

  // Field positions
  localparam int IMM_LSB = 4;
  localparam int WSEL_LSB = 0;

  // Reset values
  localparam logic [NIB_W-1:0] RESULT_RST = 4'h0;
  localparam logic [PC_W-1:0] PC_RST = 11'h000;
  localparam logic FLAG_RST = 1'b0;

  // Instruction presented for execution
  typedef struct packed {
    logic valid;
    logic [WORD_W-1:0] word;
  } nrs_instr_t;

  // One nibble write into the data RAM
  typedef struct packed {
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [NIB_W-1:0] data;
  } nrs_ram_wr_t;
endpackage

// file: verification/test_nibble_rotate_subtract_return_exec.sv
/*
  Self-checking bench for the rotate / return / subtract execution slice.
  Assumes nrs_pkg and nrs_exec are compiled first; the bench drives every port itself.
*/
`timescale 1ns/1ps
module test_nibble_rotate_subtract_return_exec;
  logic mclk;
  logic rst_n;
  nrs_pkg::nrs_instr_t instr;
  nrs_pkg::nrs_ram_wr_t ram_load;
  nrs_pkg::nrs_ram_wr_t ram_wr;
  logic [nrs_pkg::PC_W-1:0] stack_top;
  logic [nrs_pkg::PC_W-1:0] pc;
  logic [nrs_pkg::ADDR_W-1:0] peek_addr;
  logic [nrs_pkg::NIB_W-1:0] peek_data;
  logic [nrs_pkg::NIB_W-1:0] res;
  logic cf;
  logic zf;
  logic stack_pop;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;

  nrs_exec i_dut (.mclk(mclk), .rst_n(rst_n), .instr(instr), .stack_top(stack_top), .ram_load(ram_load),
    .peek_addr(peek_addr), .peek_data(peek_data), .result_nibble_register(res), .carry_flag(cf),
    .zero_flag(zf), .pc(pc), .stack_pop(stack_pop), .ram_wr(ram_wr));

  // Free-running clock, 10 ns period
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Load goes in one edge ahead of any execution so no write-back can steal it
  task automatic ld(input logic [6:0] a, input logic [3:0] d);
    @(posedge mclk) ram_load <= {1'b1, a, d};
    @(posedge mclk) ram_load.we <= 1'b0;
  endtask

  // One instruction, then look just after the edge that took it
  task automatic ex(input logic [15:0] w);
    @(posedge mclk) instr <= {1'b1, w};
    @(posedge mclk) instr.valid <= 1'b0;
    #1;
  endtask

  // Address and data of the write port only mean something while we is high
  task automatic outc(input logic [3:0] r, input logic c, input logic z, input logic wb, input logic [11:0] wr);
    chk(res, r);
    chk(cf, c);
    chk(zf, z);
    chk(ram_wr.we, wb);
    if (wb) chk(ram_wr, wr);
  endtask

  task automatic peek(input logic [6:0] a, input logic [3:0] d);
    @(posedge mclk) peek_addr <= a;
    @(posedge mclk) #1 chk(peek_data, d);
  endtask

  task automatic t_rotate();
    ld(7'h06, 4'h1);
    ld(7'h05, 4'h6);
    ex({nrs_pkg::OP_ROT_RIGHT, 7'h06});
    outc(4'h0, 1'b1, 1'b1, 1'b1, {1'b1, 7'h06, 4'h0});
    ex({nrs_pkg::OP_ROT_RIGHT, 7'h05});
    outc(4'hb, 1'b0, 1'b0, 1'b1, {1'b1, 7'h05, 4'hb});
    peek(7'h05, 4'hb);
    $display("test rotate done");
  endtask

  task automatic t_return();
    @(posedge mclk) instr <= {1'b1, nrs_pkg::OP_RETURN};
    stack_top <= 11'h5a3;
    #1 chk(stack_pop, 1'b1);
    chk(pc, 11'h002);
    @(posedge mclk) instr.valid <= 1'b0;
    #1 chk(pc, 11'h5a3);
    chk(res, 4'hb);
    chk(cf, 1'b0);
    chk(zf, 1'b0);
    chk(stack_pop, 1'b0);
    chk(ram_wr.we, 1'b0);
    $display("test return done");
  endtask

  task automatic t_subtract();
    ld(7'h20, 4'h3);
    ex({nrs_pkg::OP_SUB_MEM, 7'h20});
    outc(4'h8, 1'b1, 1'b0, 1'b0, 12'h000);
    ld(7'h21, 4'h9);
    ex({nrs_pkg::OP_SUB_MEM, 7'h21});
    outc(4'h0, 1'b0, 1'b1, 1'b0, 12'h000);
    ld(7'h03, 4'h7);
    ex({nrs_pkg::OP_SUB_IMM, 4'h9, 4'h3});
    outc(4'he, 1'b1, 1'b0, 1'b0, 12'h000);
    ld(7'h40, 4'h2);
    ex({nrs_pkg::OP_SUB_MEM_WB, 7'h40});
    outc(4'h3, 1'b1, 1'b0, 1'b1, {1'b1, 7'h40, 4'h3});
    peek(7'h40, 4'h3);
    ld(7'h04, 4'h5);
    ex({nrs_pkg::OP_SUB_IMM_WB, 4'h4, 4'h4});
    outc(4'h0, 1'b0, 1'b1, 1'b1, {1'b1, 7'h04, 4'h0});
    peek(7'h04, 4'h0);
    chk(pc, 11'h5a8);
    $display("test subtract done");
  endtask

  // Hang guard, far above the few dozen cycles the tests need
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      mismatches++;
      give_verdict();
    end
  end

  initial begin
    rst_n = 1'b0;
    instr = '0;
    ram_load = '0;
    stack_top = '0;
    peek_addr = '0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    t_rotate();
    t_return();
    t_subtract();
    give_verdict();
  end
endmodule // test_nibble_rotate_subtract_return_exec
